// File: include/msp_pkg.sv
// msp_pkg: constants, field layouts and state carriers of the serial
// configuration port.
// assumes: one 40 MHz clock; all pins already synchronous to it.
package msp_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0] ADDR_CSR = 5'h00;
  localparam logic [4:0] ADDR_FR1 = 5'h01;
  localparam logic [4:0] ADDR_FR2 = 5'h02;
  localparam logic [2:0] BYTES_CSR = 3'h1;
  localparam logic [2:0] BYTES_FR1 = 3'h3;
  localparam logic [2:0] BYTES_FR2 = 3'h2;
  localparam logic [2:0] BYTES_OTHER = 3'h4;
  localparam logic [7:0] CSR_RST = 8'hf0;
  localparam logic [23:0] FR1_RST = 24'h000000;

  // ==========================================================
  // instruction byte and lane modes
  localparam int INSTR_RW_BIT = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] MODE_2WIRE = 2'h0;
  localparam logic [1:0] MODE_3WIRE = 2'h1;
  localparam logic [1:0] MODE_2BIT = 2'h2;
  localparam logic [1:0] MODE_4BIT = 2'h3;

  // ==========================================================
  // timing: sync clock is the system clock divided by four
  localparam int SYNC_DIV = 4;
  localparam logic [1:0] SYNC_DIV_LAST = 2'(SYNC_DIV - 1);

  // ==========================================================
  // carriers
  typedef enum logic [0:0] {PH_INSTR, PH_DATA} msp_phase_t;

  typedef struct packed {
    logic [3:0] chan_en;
    logic must_zero;
    logic [1:0] mode;
    logic lsb_first;
  } msp_csr_t;

  typedef struct packed {
    msp_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic rd;
    logic [4:0] addr;
    logic [2:0] nbytes;
    logic [2:0] left;
    logic sclk_q;
    msp_csr_t csr_sh;
    logic [23:0] fr1_sh;
    msp_csr_t csr_act;
    logic [23:0] fr1_act;
    logic [3:0] sdio_out;
    logic [3:0] sdio_oe;
    logic [1:0] ramp;
  } msp_port_st_t;

  typedef struct packed {
    logic [1:0] div;
    logic upd_q;
    logic upd_pulse;
    logic sync_tick;
  } msp_upd_st_t;

endpackage

// File: rtl/msp_upd_sync.sv
// msp_upd_sync: divide-by-four sync enable and update strobe sampler.
// assumes: io_update is held high longer than one sync period.
`timescale 1ns/1ps
module msp_upd_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strobe in
  input wire logic io_update,
  // results
  output logic upd_pulse,
  output logic sync_tick
);

  localparam msp_pkg::msp_upd_st_t ST_RST = '0;

  msp_pkg::msp_upd_st_t st_r;
  msp_pkg::msp_upd_st_t st_nxt;

  // ==========================================================
  // sample the strobe only on the sync enable, pulse on its rise
  always_comb begin
    st_nxt = st_r;
    st_nxt.upd_pulse = 1'b0;
    st_nxt.sync_tick = 1'b0;
    st_nxt.div = st_r.div + 2'h1;
    if (st_r.div == msp_pkg::SYNC_DIV_LAST) begin
      st_nxt.sync_tick = 1'b1;
      st_nxt.upd_q = io_update;
      st_nxt.upd_pulse = io_update & ~st_r.upd_q;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign upd_pulse = st_r.upd_pulse;
  assign sync_tick = st_r.sync_tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_UPD_ON_TICK: assert property (
    upd_pulse |-> sync_tick)
    else $error("update pulse outside a sync tick");

endmodule // msp_upd_sync

// File: rtl/msp_port.sv
// msp_port: serial configuration port with one, two or four lanes,
// shadow and active copies of the channel select and first function registers.
// assumes: sclk, select and lanes are synchronous to clk and sclk runs
// well below clk/2, so every serial edge is seen as a level change.
`timescale 1ns/1ps
module msp_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial port
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic [3:0] sdio_in,
  output logic [3:0] sdio_out,
  output logic [3:0] sdio_oe,
  // buffered update
  input wire logic io_update,
  // active configuration and ramp controls
  output logic [3:0] chan_en,
  output logic [7:0] csr_active,
  output logic [23:0] fr1_active,
  output logic [1:0] amplitude_ramp_control
);

  localparam msp_pkg::msp_port_st_t ST_RST = '{
    phase: msp_pkg::PH_INSTR,
    csr_sh: msp_pkg::CSR_RST,
    csr_act: msp_pkg::CSR_RST,
    fr1_sh: msp_pkg::FR1_RST,
    fr1_act: msp_pkg::FR1_RST,
    default: '0
  };

  // ==========================================================
  // helper functions

  // bytes in each register
  function automatic logic [2:0] reg_bytes(input logic [4:0] a);
    case (a)
      msp_pkg::ADDR_CSR: reg_bytes = msp_pkg::BYTES_CSR;
      msp_pkg::ADDR_FR1: reg_bytes = msp_pkg::BYTES_FR1;
      msp_pkg::ADDR_FR2: reg_bytes = msp_pkg::BYTES_FR2;
      default: reg_bytes = msp_pkg::BYTES_OTHER;
    endcase
  endfunction

  // bits moved per rising edge
  function automatic logic [3:0] lane_w(input logic [1:0] m);
    case (m)
      msp_pkg::MODE_2BIT: lane_w = 4'h2;
      msp_pkg::MODE_4BIT: lane_w = 4'h4;
      default: lane_w = 4'h1;
    endcase
  endfunction

  // byte index within the register for the byte still to move
  function automatic logic [1:0] byte_idx(input logic [2:0] n,
                                          input logic [2:0] left,
                                          input logic lsb);
    logic [2:0] v;
    v = lsb ? (n - left) : (left - 3'h1);
    byte_idx = v[1:0];
  endfunction

  // shift a group of lanes into the receive byte
  function automatic logic [7:0] shift_in(input logic [7:0] b,
                                          input logic [3:0] g,
                                          input logic [1:0] m,
                                          input logic lsb);
    case (m)
      msp_pkg::MODE_4BIT:
        shift_in = lsb ? {g, b[7:4]} : {b[3:0], g};
      msp_pkg::MODE_2BIT:
        shift_in = lsb ? {g[1:0], b[7:2]} : {b[5:0], g[1:0]};
      default:
        shift_in = lsb ? {g[0], b[7:1]} : {b[6:0], g[0]};
    endcase
  endfunction

  // next group of read bits, lane k holding the group's bit k
  function automatic logic [3:0] group_out(input logic [7:0] b,
                                           input logic [1:0] m,
                                           input logic lsb);
    case (m)
      msp_pkg::MODE_4BIT: group_out = lsb ? b[3:0] : b[7:4];
      msp_pkg::MODE_2BIT: group_out = lsb ? {2'h0, b[1:0]} : {2'h0, b[7:6]};
      default: group_out = lsb ? {3'h0, b[0]} : {3'h0, b[7]};
    endcase
  endfunction

  // drop the group just driven
  function automatic logic [7:0] shift_out(input logic [7:0] b,
                                           input logic [1:0] m,
                                           input logic lsb);
    case (m)
      msp_pkg::MODE_4BIT: shift_out = lsb ? {4'h0, b[7:4]} : {b[3:0], 4'h0};
      msp_pkg::MODE_2BIT: shift_out = lsb ? {2'h0, b[7:2]} : {b[5:0], 2'h0};
      default: shift_out = lsb ? {1'h0, b[7:1]} : {b[6:0], 1'h0};
    endcase
  endfunction

  // lanes that drive read data in each mode
  function automatic logic [3:0] lane_oe(input logic [1:0] m);
    case (m)
      msp_pkg::MODE_3WIRE: lane_oe = 4'h4;
      msp_pkg::MODE_2BIT: lane_oe = 4'h3;
      msp_pkg::MODE_4BIT: lane_oe = 4'hf;
      default: lane_oe = 4'h1;
    endcase
  endfunction

  // place a read group on its lanes
  function automatic logic [3:0] lane_map(input logic [3:0] g,
                                          input logic [1:0] m);
    case (m)
      msp_pkg::MODE_3WIRE: lane_map = {1'h0, g[0], 2'h0};
      msp_pkg::MODE_2BIT: lane_map = {2'h0, g[1:0]};
      msp_pkg::MODE_4BIT: lane_map = g;
      default: lane_map = {3'h0, g[0]};
    endcase
  endfunction

  // read back one byte of the io buffer
  function automatic logic [7:0] read_byte(input logic [4:0] a,
                                           input logic [1:0] idx,
                                           input logic [7:0] channel_select_and_port_mode,
                                           input logic [23:0] fr1);
    case (a)
      msp_pkg::ADDR_CSR: read_byte = channel_select_and_port_mode;
      // index 3 only follows the last byte; keep the buffer defined
      msp_pkg::ADDR_FR1: read_byte = (idx == 2'h3) ? 8'h00 :
                                     fr1[{idx, 3'h0} +: 8];
      default: read_byte = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // state and strobes

  msp_pkg::msp_port_st_t st_r;
  msp_pkg::msp_port_st_t st_nxt;
  logic upd_pulse;
  logic rise;
  logic fall;
  logic abort_act;
  logic byte_done;
  logic [7:0] byte_new;
  logic instr_done;
  logic data_last;
  logic csr_byte_wr;
  logic [1:0] mode;
  logic lsb;
  logic [2:0] left_n;

  // update strobe on the divided sync clock
  msp_upd_sync u_upd (
    .clk(clk),
    .rstn(rstn),
    .io_update(io_update),
    .upd_pulse(upd_pulse),
    .sync_tick()
  );

  // edge detect and lane roles
  assign mode = st_r.csr_act.mode;
  assign lsb = st_r.csr_act.lsb_first;
  assign rise = sclk & ~st_r.sclk_q;
  assign fall = ~sclk & st_r.sclk_q;
  assign abort_act = sdio_in[3] & (mode != msp_pkg::MODE_4BIT);
  assign byte_done = (st_r.bitcnt + lane_w(mode)) == msp_pkg::BITS_PER_BYTE;
  assign byte_new = shift_in(st_r.rx_sh, sdio_in, mode, lsb);
  assign left_n = st_r.left - 3'h1;

  // ==========================================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    instr_done = 1'b0;
    data_last = 1'b0;
    csr_byte_wr = 1'b0;
    st_nxt.sclk_q = sclk;
    // ramp controls follow the free lanes
    st_nxt.ramp[0] = sdio_in[1] & (mode == msp_pkg::MODE_2WIRE ||
                                   mode == msp_pkg::MODE_3WIRE);
    st_nxt.ramp[1] = sdio_in[2] & (mode == msp_pkg::MODE_2WIRE ||
                                   mode == msp_pkg::MODE_2BIT);
    if (abort_act) begin
      // drop the cycle, keep every stored byte
      st_nxt.phase = msp_pkg::PH_INSTR;
      st_nxt.bitcnt = 4'h0;
      st_nxt.sdio_oe = 4'h0;
    end else if (port_select_n) begin
      st_nxt.sdio_oe = 4'h0;
    end else begin
      if (rise) begin
        st_nxt.rx_sh = byte_new;
        st_nxt.bitcnt = st_r.bitcnt + lane_w(mode);
        if (byte_done) begin
          st_nxt.bitcnt = 4'h0;
          case (st_r.phase)
            msp_pkg::PH_INSTR: begin
              instr_done = 1'b1;
              st_nxt.rd = byte_new[msp_pkg::INSTR_RW_BIT];
              st_nxt.addr = byte_new[4:0];
              st_nxt.nbytes = reg_bytes(byte_new[4:0]);
              st_nxt.left = reg_bytes(byte_new[4:0]);
              st_nxt.phase = msp_pkg::PH_DATA;
              st_nxt.tx_sh = read_byte(byte_new[4:0],
                byte_idx(reg_bytes(byte_new[4:0]),
                         reg_bytes(byte_new[4:0]), lsb),
                st_r.csr_sh, st_r.fr1_sh);
            end
            msp_pkg::PH_DATA: begin
              if (!st_r.rd) begin
                // whole byte received: store it in the CSR or FR1 shadow
                case (st_r.addr)
                  msp_pkg::ADDR_CSR: begin
                    csr_byte_wr = 1'b1;
                    st_nxt.csr_sh = byte_new;
                    st_nxt.csr_act.chan_en = byte_new[7:4];
                  end
                  msp_pkg::ADDR_FR1: begin
                    st_nxt.fr1_sh[{byte_idx(st_r.nbytes, st_r.left, lsb),
                                   3'h0} +: 8] = byte_new;
                  end
                  default: begin
                    st_nxt.rx_sh = byte_new;
                  end
                endcase
              end
              st_nxt.left = left_n;
              st_nxt.tx_sh = read_byte(st_r.addr,
                byte_idx(st_r.nbytes, left_n, lsb),
                st_r.csr_sh, st_r.fr1_sh);
              if (st_r.left == 3'h1) begin
                data_last = 1'b1;
                st_nxt.phase = msp_pkg::PH_INSTR;
                st_nxt.sdio_oe = 4'h0;
              end
            end
            default: st_nxt.phase = msp_pkg::PH_INSTR;
          endcase
        end
      end else if (fall && st_r.phase == msp_pkg::PH_DATA && st_r.rd) begin
        // read data leaves on the falling edge
        st_nxt.sdio_out = lane_map(group_out(st_r.tx_sh, mode, lsb),
                                   mode);
        st_nxt.sdio_oe = lane_oe(mode);
        st_nxt.tx_sh = shift_out(st_r.tx_sh, mode, lsb);
      end
    end
    // buffered values go live; channel enables stay as just written
    if (upd_pulse) begin
      st_nxt.csr_act = {st_nxt.csr_act.chan_en, st_r.csr_sh[3:0]};
      st_nxt.fr1_act = st_r.fr1_sh;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all from the state register
  assign sdio_out = st_r.sdio_out;
  assign sdio_oe = st_r.sdio_oe;
  assign chan_en = st_r.csr_act.chan_en;
  assign csr_active = st_r.csr_act;
  assign fr1_active = st_r.fr1_act;
  assign amplitude_ramp_control = st_r.ramp;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_RW_FLAG: assert property (
    instr_done |=> st_r.rd == $past(byte_new[7]))
    else $error("direction flag not taken from instruction bit 7");

  AST_ADDR_FIELD: assert property (
    instr_done |=> st_r.addr == $past(byte_new[4:0]))
    else $error("address not taken from low five instruction bits");

  AST_FR1_LEN: assert property (
    instr_done && byte_new[4:0] == msp_pkg::ADDR_FR1
      |=> st_r.left == 3'h3 && st_r.phase == msp_pkg::PH_DATA)
    else $error("function register one not three bytes long");

  AST_BACK_TO_INSTR: assert property (
    data_last |=> st_r.phase == msp_pkg::PH_INSTR && st_r.bitcnt == 4'h0)
    else $error("cycle did not return to instruction phase");

  AST_OUT_ON_FALL: assert property (
    !fall |=> $stable(st_r.sdio_out))
    else $error("read data changed away from a falling edge");

  AST_ACTIVE_HOLDS: assert property (
    !upd_pulse |=> $stable(st_r.fr1_act))
    else $error("active register changed without update");

  AST_CHAN_NOW: assert property (
    csr_byte_wr |=> chan_en == $past(byte_new[7:4]))
    else $error("channel enables not live after their byte");

  AST_DESELECT_OFF: assert property (
    port_select_n |=> sdio_oe == 4'h0)
    else $error("lanes driven while deselected");

  AST_ABORT_IDLE: assert property (
    abort_act |=> st_r.phase == msp_pkg::PH_INSTR && sdio_oe == 4'h0
      && $stable(st_r.fr1_sh))
    else $error("abort did not reset the sequencer");

  AST_NO_SDO_2BIT: assert property (
    $past(mode) == msp_pkg::MODE_2BIT || $past(mode) == msp_pkg::MODE_2WIRE
      |-> !sdio_oe[2])
    else $error("lane two driven outside three-wire or four-bit mode");

  AST_ABORT_4BIT: assert property (
    mode == msp_pkg::MODE_4BIT && sdio_in[3] && rise && !port_select_n
      && !byte_done |=> st_r.bitcnt == $past(st_r.bitcnt) + 4'h4)
    else $error("lane three high cut a four-bit transfer");

  COV_FR1_WRITE: cover property (
    data_last && !st_r.rd && st_r.addr == msp_pkg::ADDR_FR1);
  COV_READ_DONE: cover property (data_last && st_r.rd);
  COV_ABORT_DATA: cover property (
    abort_act && st_r.phase == msp_pkg::PH_DATA);
  COV_4BIT_INSTR: cover property (
    instr_done && mode == msp_pkg::MODE_4BIT);

endmodule // msp_port

// File: tb/msp_host.sv
// msp_host: behavioural host that clocks bytes through the serial port.
// assumes: bench resolves each lane from sdio_oe; sclk levels last 2 clk.
`timescale 1ns/1ps
module msp_host (
  // clock
  input wire logic clk,
  // serial side
  output logic sclk,
  output logic port_select_n,
  output logic [3:0] sdio_drv,
  input wire logic [3:0] sdio_lane,
  input wire logic [3:0] sdio_oe
);
  logic [3:0] oe_seen;

  // ==========================================================
  // idle levels: clock low, deselected, abort lane low
  initial begin
    sclk = 1'b0;
    port_select_n = 1'b1;
    sdio_drv = 4'h0;
    oe_seen = 4'h0;
  end

  // ==========================================================
  // move the first ne edge groups of one byte in mode m
  task automatic shift(input logic [7:0] tx, input logic [1:0] m,
      input logic lsb, input logic rd, input int ne,
      output logic [7:0] rx);
    int w;
    int g;
    w = (m == 2'h3) ? 4 : (m == 2'h2) ? 2 : 1;
    rx = 8'h00;
    for (int e = 0; e < ne; e++) begin
      g = lsb ? e : 8 / w - 1 - e;
      @(posedge clk) #2;
      sclk = 1'b0;
      sdio_drv = 4'h0; // lane three stays low outside 4-bit data
      for (int k = 0; k < w; k++) begin
        if (!rd) sdio_drv[k] = tx[g * w + k];
      end
      repeat (2) @(posedge clk);
      #2;
      if (rd) begin
        oe_seen = oe_seen | sdio_oe;
        for (int k = 0; k < w; k++) begin
          rx[g * w + k] = sdio_lane[(m == 2'h1) ? 2 : k];
        end
      end
      sclk = 1'b1; // data held across the rise
      @(posedge clk);
    end
  endtask

  // ==========================================================
  // select and lane level changes
  task automatic select_n(input logic v);
    @(posedge clk) #2;
    port_select_n = v;
  endtask

  task automatic lanes(input logic [3:0] v);
    @(posedge clk) #2;
    sdio_drv = v;
  endtask
endmodule // msp_host

// File: tb/multi_lane_serial_config_port_bench.sv
// bench for msp_port: host model drives the lanes, a register model
// predicts shadow and active contents.
// assumes: msp_host model and msp_pkg compiled first.
`timescale 1ns/1ps
module multi_lane_serial_config_port_bench;
  logic clk, rstn, io_update, sclk, port_select_n;
  logic [3:0] sdio_drv, sdio_out, sdio_oe, sdio_lane, chan_en;
  logic [7:0] csr_active, m_csr_sh, m_csr_act;
  logic [23:0] fr1_active, m_fr1_sh, m_fr1_act, v;
  logic [31:0] q;
  logic [1:0] ramp;
  logic [3:0] m_chan;
  int n_fail, n_checks, cyc;

  // ==========================================================
  // lane wire: device wins where it drives
  assign sdio_lane = (sdio_oe & sdio_out) | (~sdio_oe & sdio_drv);

  msp_port u_dut (.clk(clk), .rstn(rstn), .sclk(sclk),
    .port_select_n(port_select_n), .sdio_in(sdio_lane),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .io_update(io_update),
    .chan_en(chan_en), .csr_active(csr_active), .fr1_active(fr1_active),
    .amplitude_ramp_control(ramp));
  msp_host u_host (.clk(clk), .sclk(sclk), .port_select_n(port_select_n),
    .sdio_drv(sdio_drv), .sdio_lane(sdio_lane), .sdio_oe(sdio_oe));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // ==========================================================
  // compares and verdict
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_lane(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // one cycle in the active mode; cut stops mid byte, -2 pauses select
  task automatic xfer(input logic rdn, input logic [6:0] a, input int nb,
      input logic [31:0] wd, input int cut, output logic [31:0] qo);
    logic [1:0] m;
    logic lsb;
    logic [7:0] b;
    int i;
    int ef;
    m = m_csr_act[2:1];
    lsb = m_csr_act[0];
    ef = (m == 2'h3) ? 2 : (m == 2'h2) ? 4 : 8;
    qo = 32'h0;
    u_host.oe_seen = 4'h0;
    u_host.select_n(1'b0);
    u_host.shift({rdn, a}, m, lsb, 1'b0, ef, b);
    for (int j = 0; j < nb; j++) begin
      i = lsb ? j : nb - 1 - j;
      if (j == 1 && cut == -2) begin
        u_host.select_n(1'b1);
        repeat (3) @(posedge clk);
        chk_lane(sdio_oe, 4'h0);
        u_host.select_n(1'b0);
      end
      u_host.shift(wd[i*8 +: 8], m, lsb, rdn, (j == cut) ? ef / 2 : ef, b);
      qo[i*8 +: 8] = b;
      if (j == cut) return;
    end
    u_host.select_n(1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input int nb, input logic [31:0] wd);
    xfer(1'b0, a, nb, wd, -1, q);
    if (a[4:0] == 5'h00) begin
      m_csr_sh = wd[7:0];
      m_chan = wd[7:4];
      m_csr_act[7:4] = wd[7:4];
    end
    if (a[4:0] == 5'h01) m_fr1_sh = wd[23:0];
  endtask

  task automatic rdchk(input logic [6:0] a, input int nb,
      input logic [31:0] exp);
    logic [15:0] oe_tbl;
    oe_tbl = 16'hf341;
    xfer(1'b1, a, nb, 32'h0, -2, q);
    chk_reg(q, exp);
    chk_lane(u_host.oe_seen, oe_tbl[m_csr_act[2:1]*4 +: 4]);
  endtask

  task automatic upd();
    chk_reg({8'h00, fr1_active}, {8'h00, m_fr1_act});
    @(posedge clk) #2;
    io_update = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    io_update = 1'b0;
    repeat (4) @(posedge clk);
    m_fr1_act = m_fr1_sh;
    m_csr_act = {m_chan, m_csr_sh[3:0]};
    chk_reg({8'h00, fr1_active}, {8'h00, m_fr1_act});
    chk_reg({24'h0, csr_active}, {24'h0, m_csr_act});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    io_update = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    m_csr_sh = 8'hf0;
    m_csr_act = 8'hf0;
    m_chan = 4'hf;
    m_fr1_sh = 24'h0;
    m_fr1_act = 24'h0;
    void'($urandom(32'ha824));
    repeat (5) @(posedge clk);
    #2;
    rstn = 1'b1;
    @(posedge clk) #2;
    chk_reg({24'h0, csr_active}, 32'hf0); // reset value of the select reg
    chk_lane(chan_en, 4'hf);
    chk_lane(sdio_oe | {2'h0, ramp}, 4'h0);
    // idle lanes one and two steer the ramp controls
    for (int r = 0; r < 4; r++) begin
      u_host.lanes({1'b0, 2'(r), 1'b0});
      repeat (3) @(posedge clk);
      chk_lane({2'h0, ramp}, 4'(r));
    end
    u_host.lanes(4'h0);
    // shadow write, readback, update
    v = 24'($urandom);
    wr(7'h01, 3, {8'h00, v});
    rdchk(7'h01, 3, {8'h00, m_fr1_sh});
    upd();
    // ignored instruction bits and unmapped places
    v = 24'($urandom);
    wr(7'h61, 3, {8'h00, v});
    wr(7'h05, 4, $urandom);
    wr(7'h02, 2, $urandom);
    rdchk(7'h05, 4, 32'h0);
    rdchk(7'h02, 2, 32'h0);
    rdchk(7'h01, 3, {8'h00, m_fr1_sh});
    // abort after one whole byte and half of the next
    v = 24'($urandom);
    xfer(1'b0, 7'h01, 3, {8'h00, v}, 1, q);
    u_host.lanes(4'h8);
    repeat (3) @(posedge clk);
    u_host.lanes(4'h0);
    u_host.select_n(1'b1);
    m_fr1_sh[23:16] = v[23:16];
    rdchk(7'h01, 3, {8'h00, m_fr1_sh});
    // every mode with both bit orders
    for (int md = 0; md < 8; md++) begin
      v = 24'($urandom);
      wr(7'h00, 1, {24'h0, v[7:4], 1'b0, 2'(md), md[2]});
      chk_lane(chan_en, m_chan);
      chk_reg({24'h0, csr_active}, {24'h0, m_csr_act});
      upd();
      v = 24'($urandom);
      wr(7'h01, 3, {8'h00, v});
      rdchk(7'h01, 3, {8'h00, m_fr1_sh});
      rdchk(7'h00, 1, {24'h0, m_csr_sh});
      upd();
    end
    // reset in mid-run returns the active registers to their defaults
    @(posedge clk) #2;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rstn = 1'b1;
    @(posedge clk) #2;
    chk_reg({csr_active, fr1_active}, {8'hf0, 24'h0});
    chk_lane(chan_en, 4'hf);
    print_verdict();
  end
endmodule // multi_lane_serial_config_port_bench
